//--- hdl/tsb_irq_ctrl.sv
/*
 * Time-stamp buffer clear command, raw capture-memory page window and the
 * event interrupt aggregation onto an open-drain interrupt pin.
 * Assumes a classic Wishbone master with 8-bit data on the same clock, and a
 * capture path on the same clock that pulses cap_store_i per stored stamp.
 */
// Notes on behaviour
// - Host sets per-buffer clear enables then writes trigger; device clears flags and pointer.
// - Trigger field returns to zero once the command has finished.
// - Clear command acts on each buffer only where its clear enable is set.
// - Clear command never touches capture memory contents.
// - In raw mode, window writes land in the page chosen by page select.
// - Threshold flag sets when stored count reaches threshold; zero threshold never sets.
// - Input event flag sets on a trigger only while its enable is set.
// - Battery-low flag sets on a detected drop only when enabled.
// - Second-level supply flag sets on a detected drop only when enabled.
// - Main-supply flag sets on a detected drop only when enabled.
// - Oscillator-halt flag sets on a detected stop only when enabled.
// - Writing zero clears any buffer or event flag.
// - Any set factor flag also sets the summary flag.
// - Summary flag with master enable drives the interrupt pin low.
// - Summary clear releases the interrupt pin.
// - Index decodes as bank in upper nibble, address in lower nibble.
// - Reserved bits ignore writes and read zero; general bits store.
`timescale 1ns/1ps
module tsb_irq_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [0:0] wb_sel_i,
	input wire logic [7:0] wb_dat_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] event_input_pin_i,
	input wire logic battery_low_i,
	input wire logic second_level_low_i,
	input wire logic main_supply_low_i,
	input wire logic osc_halt_i,
	input wire logic [2:0] cap_store_i,
	output logic int_n_o,
	output logic int_n_oe_o
);
	logic ack_ff;
	logic [7:0] dat_ff;
	logic [7:0] enable_ff;
	logic [7:0] cmd_cfg_ff;
	logic [7:0] trig_ff;
	logic [7:0] buffer1_config_two_ff;
	logic [7:0] evt_en_ff;
	logic [2:0] buf_flags_ff;
	logic [6:0] evt_flags_ff;
	logic summary_ff;
	logic int_oe_ff;
	logic int_lvl_ff;
	tsb_pkg::tsb_cmd_t cmd_state_ff;
	logic [7:0] cfg1_ff [3];
	logic [5:0] ptr_ff [3];
	logic [7:0] mem [256];
	logic [6:0] sync1_ff;
	logic [6:0] sync2_ff;
	logic [6:0] sync3_ff;
	logic [6:0] level_ff;
	logic [6:0] evt_raw;
	logic [6:0] evt_hit;
	logic [7:0] idx;
	logic [7:0] win_adr;
	logic req;
	logic wr;
	logic trg_go;
	logic clr_exec;
	logic [7:0] rdata;

	// Bus decode; byte lanes are a single lane, sel gates the write
	assign idx = wb_adr_i[9:2];
	assign win_adr = {buffer1_config_two_ff[3:0], idx[3:0]}; // Page on top, window offset below
	assign req = wb_cyc_i && wb_stb_i;
	assign wr = req && wb_we_i && ack_ff && wb_sel_i[0]; // Write lands at the ack edge
	assign trg_go = wr && (idx == tsb_pkg::ADR_CMD_TRG) && (cmd_state_ff == tsb_pkg::CMD_IDLE);
	assign clr_exec = (cmd_state_ff == tsb_pkg::CMD_EXEC);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= req && !ack_ff;
	end

	// Read data captured with the ack; unmapped indexes answer zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_ff <= tsb_pkg::RST_REG;
		else if (req && !ack_ff)
			dat_ff <= rdata;
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// Read mux; bank and in-bank address come from the index nibbles
	always_comb
	begin
		rdata = 8'h00;
		if (idx[7:4] == tsb_pkg::BANK_WINDOW)
			rdata = mem[win_adr];
		else if (idx == tsb_pkg::ADR_STATUS)
			rdata = 8'(summary_ff) << tsb_pkg::BIT_SUMMARY;
		else if (idx == tsb_pkg::ADR_ENABLE)
			rdata = enable_ff;
		else if (idx == tsb_pkg::ADR_BUFFER1_CONFIG_TWO)
			rdata = buffer1_config_two_ff;
		else if (idx == tsb_pkg::ADR_CMD_CFG)
			rdata = cmd_cfg_ff;
		else if (idx == tsb_pkg::ADR_CMD_TRG)
			rdata = trig_ff;
		else if (idx == tsb_pkg::ADR_BUF_FLAGS)
			rdata = {5'h00, buf_flags_ff};
		else if (idx == tsb_pkg::ADR_EVT_FLAGS)
			rdata = {1'h0, evt_flags_ff};
		else if (idx == tsb_pkg::ADR_EVT_ENABLES)
			rdata = evt_en_ff;
		else
		begin
			for (int b = 0; b < 3; b++)
			begin
				if (idx == 8'(tsb_pkg::ADR_BUF_CFG1_BASE + 8'(b) * tsb_pkg::ADR_BUF_STRIDE))
					rdata = cfg1_ff[b];
				else if (idx == 8'(tsb_pkg::ADR_BUF_STAT_BASE + 8'(b) * tsb_pkg::ADR_BUF_STRIDE))
					rdata = {ptr_ff[b] == tsb_pkg::BUF_DEPTHS[6*b +: 6],
						ptr_ff[b] == tsb_pkg::RST_PTR, ptr_ff[b]};
			end
		end
	end

	// Plain control registers; reserved positions masked off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			enable_ff <= tsb_pkg::RST_REG;
			cmd_cfg_ff <= tsb_pkg::RST_REG;
			buffer1_config_two_ff <= tsb_pkg::RST_REG;
			evt_en_ff <= tsb_pkg::RST_REG;
		end
		else if (wr)
		begin
			if (idx == tsb_pkg::ADR_ENABLE)
				enable_ff <= wb_dat_i & tsb_pkg::MASK_ENABLE;
			else if (idx == tsb_pkg::ADR_CMD_CFG)
				cmd_cfg_ff <= wb_dat_i & tsb_pkg::MASK_CMD_CFG;
			else if (idx == tsb_pkg::ADR_BUFFER1_CONFIG_TWO)
				buffer1_config_two_ff <= wb_dat_i & tsb_pkg::MASK_BUFFER1_CONFIG_TWO;
			else if (idx == tsb_pkg::ADR_EVT_ENABLES)
				evt_en_ff <= wb_dat_i & tsb_pkg::MASK_EVT;
		end
	end

	// Command sequencer: take trigger, clear selected buffers, then zero field
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cmd_state_ff <= tsb_pkg::CMD_IDLE;
		else
		begin
			case (cmd_state_ff)
				tsb_pkg::CMD_IDLE:
					if (trg_go)
						cmd_state_ff <= tsb_pkg::CMD_EXEC;
				tsb_pkg::CMD_EXEC:
					cmd_state_ff <= tsb_pkg::CMD_DONE;
				default:
					cmd_state_ff <= tsb_pkg::CMD_IDLE;
			endcase
		end
	end

	// Trigger field holds the written value until the command completes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			trig_ff <= tsb_pkg::RST_REG;
		else if (trg_go)
			trig_ff <= wb_dat_i;
		else if (cmd_state_ff == tsb_pkg::CMD_DONE)
			trig_ff <= tsb_pkg::RST_REG;
	end

	// Raw page window; the clear command has no path into this array
	always_ff @(posedge clk_i)
	begin
		if (wr && buffer1_config_two_ff[tsb_pkg::BIT_RAW_MODE] && idx[7:4] == tsb_pkg::BANK_WINDOW)
			mem[win_adr] <= wb_dat_i;
	end

	// Per buffer: threshold config, stamp pointer and threshold flag
	generate
		for (genvar b = 0; b < 3; b++)
		begin : g_buf
			logic [7:0] cfg_adr;
			logic [5:0] depth;
			logic [5:0] nxt_ptr;
			logic stored;
			logic hit;
			logic clr_flag;
			assign cfg_adr = 8'(tsb_pkg::ADR_BUF_CFG1_BASE + 8'(b) * tsb_pkg::ADR_BUF_STRIDE);
			assign depth = tsb_pkg::BUF_DEPTHS[6*b +: 6];
			assign stored = cap_store_i[b] && (ptr_ff[b] != depth || cfg1_ff[b][6]);
			assign nxt_ptr = (ptr_ff[b] == depth) ? tsb_pkg::PTR_WRAP : 6'(ptr_ff[b] + 6'h01);
			// Zero threshold never matches a nonzero count
			assign hit = stored && cfg1_ff[b][5:0] != 6'h00 && nxt_ptr == cfg1_ff[b][5:0];
			assign clr_flag = wr && idx == tsb_pkg::ADR_BUF_FLAGS && !wb_dat_i[b];

			// Threshold register; buffer 1 has six count bits, others four
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cfg1_ff[b] <= tsb_pkg::RST_REG;
				else if (wr && idx == cfg_adr)
					cfg1_ff[b] <= wb_dat_i & ((b == 0) ? tsb_pkg::MASK_BUF1_CFG1
						: tsb_pkg::MASK_BUFX_CFG1);
			end

			// Pointer; the clear command outranks a store in the same cycle
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					ptr_ff[b] <= tsb_pkg::RST_PTR;
				else if (clr_exec && cmd_cfg_ff[tsb_pkg::BIT_FCLR_BASE + b])
					ptr_ff[b] <= tsb_pkg::RST_PTR;
				else if (stored)
					ptr_ff[b] <= nxt_ptr;
			end

			// Flag: set wins over a host clear, command clear is a reset of state
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					buf_flags_ff[b] <= 1'b0;
				else if (clr_exec && cmd_cfg_ff[tsb_pkg::BIT_FCLR_BASE + b])
					buf_flags_ff[b] <= 1'b0;
				else
					buf_flags_ff[b] <= (buf_flags_ff[b] && !clr_flag) || hit;
			end
		end
	endgenerate

	// Event sources: three pins then the four monitors, all asynchronous
	assign evt_raw = {battery_low_i, second_level_low_i, main_supply_low_i, osc_halt_i,
		event_input_pin_i};

	// Three-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
			sync3_ff <= 7'h00;
		end
		else
		begin
			sync1_ff <= evt_raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// Debounced level moves only where stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			level_ff <= 7'h00;
		else
			level_ff <= (level_ff & (sync2_ff ^ sync3_ff)) | (sync2_ff & sync3_ff);
	end

	// Rising edge of an agreed level is one event
	assign evt_hit = sync2_ff & sync3_ff & ~level_ff;

	// Event flags, each gated by its own enable
	generate
		for (genvar e = 0; e < 7; e++)
		begin : g_evt
			logic set_evt;
			logic clr_evt;
			assign set_evt = evt_hit[e] && evt_en_ff[e];
			assign clr_evt = wr && idx == tsb_pkg::ADR_EVT_FLAGS && !wb_dat_i[e];

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					evt_flags_ff[e] <= 1'b0;
				else
					evt_flags_ff[e] <= (evt_flags_ff[e] && !clr_evt) || set_evt;
			end
		end
	endgenerate

	// Summary follows the factor flags; host writes have no path here
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			summary_ff <= 1'b0;
		else
			summary_ff <= (|buf_flags_ff) || (|evt_flags_ff);
	end

	// Open-drain pin: value is always low, enable tracks summary and master enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			int_oe_ff <= 1'b0;
			int_lvl_ff <= 1'b0;
		end
		else
		begin
			int_oe_ff <= summary_ff && enable_ff[tsb_pkg::BIT_MASTER_EN];
			int_lvl_ff <= 1'b0;
		end
	end

	assign int_n_o = int_lvl_ff;
	assign int_n_oe_o = int_oe_ff;

	// Checks on the block's own outputs and state
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_TRG_CLEARS: assert property (trg_go |-> ##3 trig_ff == 8'h00)
		else $error("trigger field did not return to zero");
	AST_CLR_PTR: assert property (trg_go && cmd_cfg_ff[tsb_pkg::BIT_FCLR_BASE]
		|-> ##2 ptr_ff[0] == 6'h00)
		else $error("buffer pointer not cleared by command");
	AST_KEEP_OTHER: assert property (clr_exec && !cmd_cfg_ff[tsb_pkg::BIT_FCLR_BASE + 1]
		&& !cap_store_i[1]
		|=> ptr_ff[1] == $past(ptr_ff[1]))
		else $error("unselected buffer pointer changed");
	AST_RAW_WRITE: assert property (wr && buffer1_config_two_ff[tsb_pkg::BIT_RAW_MODE]
		&& idx[7:4] == tsb_pkg::BANK_WINDOW
		|=> mem[$past(win_adr)] == $past(wb_dat_i))
		else $error("raw window write lost");
	AST_ZERO_THR: assert property (cfg1_ff[0][5:0] == 6'h00 && !buf_flags_ff[0]
		|=> !buf_flags_ff[0])
		else $error("threshold flag set with zero threshold");
	AST_EVT_GATED: assert property (!evt_en_ff[0] && !evt_flags_ff[0]
		|=> !evt_flags_ff[0])
		else $error("input flag set while disabled");
	AST_BATT_GATED: assert property (!evt_en_ff[6] && !evt_flags_ff[6]
		|=> !evt_flags_ff[6])
		else $error("battery flag set while disabled");
	AST_CLR_ZERO: assert property (wr && idx == tsb_pkg::ADR_EVT_FLAGS && !wb_dat_i[3]
		&& !evt_hit[3]
		|=> !evt_flags_ff[3])
		else $error("flag not cleared by zero write");
	AST_ONE_KEEPS: assert property (wr && idx == tsb_pkg::ADR_BUF_FLAGS && wb_dat_i[2]
		&& buf_flags_ff[2]
		&& !clr_exec |=> buf_flags_ff[2])
		else $error("flag lost on write of one");
	AST_SET_WINS: assert property (evt_hit[1] && evt_en_ff[1] |=> evt_flags_ff[1])
		else $error("event lost against clear");
	AST_SUMMARY: assert property ((|evt_flags_ff) || (|buf_flags_ff) |=> summary_ff)
		else $error("summary not set by factor");
	AST_SUMMARY_HOLD: assert property (!(|evt_flags_ff) && !(|buf_flags_ff)
		|=> !summary_ff)
		else $error("summary held with no factor");
	AST_PIN_LOW: assert property (summary_ff && enable_ff[tsb_pkg::BIT_MASTER_EN]
		|=> int_n_oe_o && !int_n_o)
		else $error("interrupt pin not driven low");
	AST_PIN_REL: assert property (!summary_ff |=> !int_n_oe_o)
		else $error("interrupt pin not released");

	COV_CMD: cover property (trg_go ##3 trig_ff == 8'h00);
	COV_IRQ: cover property (evt_hit[0] && evt_en_ff[0] ##[1:4] int_n_oe_o);
	COV_RAW: cover property (wr && buffer1_config_two_ff[tsb_pkg::BIT_RAW_MODE]
		&& idx[7:4] == tsb_pkg::BANK_WINDOW);
	COV_THR: cover property (g_buf[0].hit);
endmodule

//--- inc/tsb_pkg.sv
/*
 * Constants for the time-stamp buffer clear and interrupt block: register
 * indexes, field positions, reset values and buffer depths.
 * Assumes an 8-bit register space of 256 indexes, byte address = 4 * index.
 */
package tsb_pkg;
	// Register indexes, upper nibble is the bank
	localparam logic [7:0] ADR_STATUS = 8'h0E;
	localparam logic [7:0] ADR_ENABLE = 8'h0F;
	localparam logic [7:0] ADR_BUF_CFG1_BASE = 8'h27;
	localparam logic [7:0] ADR_BUF_STAT_BASE = 8'h28;
	localparam logic [7:0] ADR_BUF_STRIDE = 8'h03;
	localparam logic [7:0] ADR_BUFFER1_CONFIG_TWO = 8'h29;
	localparam logic [7:0] ADR_CMD_CFG = 8'h41;
	localparam logic [7:0] ADR_CMD_TRG = 8'h42;
	localparam logic [7:0] ADR_BUF_FLAGS = 8'h44;
	localparam logic [7:0] ADR_EVT_FLAGS = 8'h45;
	localparam logic [7:0] ADR_EVT_ENABLES = 8'h46;
	localparam logic [3:0] BANK_WINDOW = 4'h6;
	// Field positions
	localparam int BIT_SUMMARY = 2;
	localparam int BIT_MASTER_EN = 2;
	localparam int BIT_RAW_MODE = 6;
	localparam int BIT_FCLR_BASE = 4;
	localparam int BIT_STAT_FULL = 7;
	localparam int BIT_STAT_EMPTY = 6;
	localparam int EVT_OSC = 3;
	localparam int EVT_MAIN = 4;
	localparam int EVT_SECOND = 5;
	localparam int EVT_BATT = 6;
	// Writable masks, reserved bits read zero
	localparam logic [7:0] MASK_ENABLE = 8'hFD;
	localparam logic [7:0] MASK_CMD_CFG = 8'hF1;
	localparam logic [7:0] MASK_BUFFER1_CONFIG_TWO = 8'hCF;
	localparam logic [7:0] MASK_EVT = 8'h7F;
	localparam logic [7:0] MASK_BUF1_CFG1 = 8'h7F;
	localparam logic [7:0] MASK_BUFX_CFG1 = 8'h4F;
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [5:0] RST_PTR = 6'h00;
	// Depths in stamps for buffers 3, 2, 1
	localparam logic [17:0] BUF_DEPTHS = {6'h0A, 6'h0C, 6'h0A};
	localparam logic [5:0] PTR_WRAP = 6'h01;
	// Command sequencer, Gray coded along idle, exec, done
	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_EXEC = 2'b01,
		CMD_DONE = 2'b11
	} tsb_cmd_t;
endpackage

//--- sim/tsb_host_model.sv
/*
 * Host-side model: single-byte classic Wishbone cycles and the board pull-up
 * on the open-drain interrupt line.
 * Assumes the bench owns the clock and the slave answers with a one-cycle ack.
 */
`timescale 1ns/1ps
module tsb_host_model (
	input wire logic clk_i,
	input wire logic wb_ack_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic int_n_i,
	input wire logic int_n_oe_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [9:0] wb_adr_o,
	output logic [0:0] wb_sel_o,
	output logic [7:0] wb_dat_o,
	output logic int_line_o
);
	// Pull-up: a released pin reads high, never the last driven value
	assign int_line_o = int_n_oe_i ? int_n_i : 1'h1;
	// Bus idle from time zero
	initial
	begin
		wb_cyc_o = 1'h0;
		wb_stb_o = 1'h0;
		wb_we_o = 1'h0;
		wb_adr_o = 10'h000;
		wb_sel_o = 1'h1;
		wb_dat_o = 8'h00;
	end
	// One byte per cycle, request held until ack is sampled at an edge
	task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		wb_cyc_o <= 1'h1;
		wb_stb_o <= 1'h1;
		wb_we_o <= we;
		wb_sel_o <= 1'h1;
		wb_adr_o <= {idx, 2'h0};
		wb_dat_o <= d;
		do
			@(posedge clk_i);
		while (wb_ack_i !== 1'h1);
		q = wb_dat_i;
		wb_cyc_o <= 1'h0;
		wb_stb_o <= 1'h0;
		wb_we_o <= 1'h0;
	endtask
endmodule

//--- sim/tsb_irq_ctrl_tb.sv
/*
 * Self-checking bench: register accesses through the host model, event and
 * store pulses on the side inputs, interrupt line watched through the pull-up.
 * Assumes the block acks each access and clears buffers within a few edges.
 */
`timescale 1ns/1ps
module tsb_irq_ctrl_tb;
	logic clk_i, rst_i, battery_low_i, second_level_low_i, main_supply_low_i, osc_halt_i;
	logic [2:0] event_input_pin_i;
	logic [2:0] cap_store_i;
	logic wb_cyc, wb_stb, wb_we, wb_ack, int_n, int_n_oe, int_line;
	logic [9:0] wb_adr;
	logic [0:0] wb_sel;
	logic [7:0] wb_wdat, wb_rdat, rd;
	int bad_count, samples_checked, cycles;
	tsb_irq_ctrl tsb_irq_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.event_input_pin_i(event_input_pin_i), .battery_low_i(battery_low_i),
		.second_level_low_i(second_level_low_i), .main_supply_low_i(main_supply_low_i),
		.osc_halt_i(osc_halt_i), .cap_store_i(cap_store_i), .int_n_o(int_n),
		.int_n_oe_o(int_n_oe));
	tsb_host_model tsb_host_model_inst (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat),
		.int_n_i(int_n), .int_n_oe_i(int_n_oe), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
		.wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
		.int_line_o(int_line));
	// 100 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		tsb_host_model_inst.access(1'h1, idx, d, rd);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
		tsb_host_model_inst.access(1'h0, idx, 8'h00, rd);
		check(rd & m, exp);
	endtask
	// Pulses long enough to pass the input synchronisers
	task automatic events();
		@(posedge clk_i);
		event_input_pin_i <= 3'h7;
		{battery_low_i, second_level_low_i, main_supply_low_i, osc_halt_i} <= 4'hF;
		repeat (6) @(posedge clk_i);
		event_input_pin_i <= 3'h0;
		{battery_low_i, second_level_low_i, main_supply_low_i, osc_halt_i} <= 4'h0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic store(input logic [2:0] b);
		@(posedge clk_i);
		cap_store_i <= b;
		@(posedge clk_i);
		cap_store_i <= 3'h0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far above the length of the sequence
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			results();
		end
	end
	// Main sequence
	initial
	begin
		rst_i = 1'h1;
		event_input_pin_i = 3'h0;
		{battery_low_i, second_level_low_i, main_supply_low_i, osc_halt_i} = 4'h0;
		cap_store_i = 3'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		rdchk(tsb_pkg::ADR_STATUS, 8'h00, 8'hFF);
		wr(tsb_pkg::ADR_ENABLE, 8'hFF);
		rdchk(tsb_pkg::ADR_ENABLE, tsb_pkg::MASK_ENABLE, 8'hFF);
		wr(tsb_pkg::ADR_ENABLE, 8'h00);
		rdchk(tsb_pkg::ADR_CMD_CFG, 8'h00, 8'hFF);
		// Only input 1 enabled: every other factor must stay clear
		wr(tsb_pkg::ADR_EVT_ENABLES, 8'h01);
		events();
		rdchk(tsb_pkg::ADR_EVT_FLAGS, 8'h01, 8'hFF);
		rdchk(tsb_pkg::ADR_STATUS, 8'h04, 8'hFF);
		check({7'h00, int_line}, 8'h01);
		wr(tsb_pkg::ADR_EVT_FLAGS, 8'h00);
		wr(tsb_pkg::ADR_EVT_ENABLES, tsb_pkg::MASK_EVT);
		events();
		rdchk(tsb_pkg::ADR_EVT_FLAGS, 8'h7F, 8'hFF);
		wr(tsb_pkg::ADR_ENABLE, 8'h04);
		repeat (3) @(posedge clk_i);
		check({7'h00, int_line}, 8'h00);
		wr(tsb_pkg::ADR_EVT_FLAGS, 8'h7E);
		rdchk(tsb_pkg::ADR_EVT_FLAGS, 8'h7E, 8'hFF);
		wr(tsb_pkg::ADR_STATUS, 8'h00);
		rdchk(tsb_pkg::ADR_STATUS, 8'h04, 8'hFF);
		wr(tsb_pkg::ADR_EVT_FLAGS, 8'h00);
		rdchk(tsb_pkg::ADR_STATUS, 8'h00, 8'hFF);
		repeat (3) @(posedge clk_i);
		check({7'h00, int_line}, 8'h01);
		// Buffer 1 threshold 2, buffers 2 and 3 threshold zero
		wr(tsb_pkg::ADR_BUF_CFG1_BASE, 8'h02);
		store(3'h7);
		rdchk(tsb_pkg::ADR_BUF_FLAGS, 8'h00, 8'hFF);
		store(3'h7);
		rdchk(tsb_pkg::ADR_BUF_FLAGS, 8'h01, 8'hFF);
		rdchk(tsb_pkg::ADR_STATUS, 8'h04, 8'hFF);
		wr(tsb_pkg::ADR_BUFFER1_CONFIG_TWO, 8'h43);
		wr(8'h65, 8'h5A);
		rdchk(8'h65, 8'h5A, 8'hFF);
		// Empty buffer 1 only
		wr(tsb_pkg::ADR_CMD_CFG, 8'h10);
		wr(tsb_pkg::ADR_CMD_TRG, 8'hA5);
		for (int n = 0; n < 20; n++)
		begin
			tsb_host_model_inst.access(1'h0, tsb_pkg::ADR_CMD_TRG, 8'h00, rd);
			if (rd === 8'h00)
				break;
		end
		check(rd, 8'h00);
		rdchk(tsb_pkg::ADR_BUF_STAT_BASE, 8'h00, 8'h3F);
		rdchk(tsb_pkg::ADR_BUF_FLAGS, 8'h00, 8'hFF);
		rdchk(8'h2B, 8'h02, 8'h0F);
		rdchk(8'h65, 8'h5A, 8'hFF);
		// Zero the whole memory page by page, then leave raw mode
		for (int p = 0; p < 16; p++)
		begin
			wr(tsb_pkg::ADR_BUFFER1_CONFIG_TWO, 8'h40 | 8'(p));
			for (int a = 0; a < 16; a++)
				wr(8'h60 + 8'(a), 8'h00);
		end
		wr(tsb_pkg::ADR_BUFFER1_CONFIG_TWO, 8'h03);
		rdchk(8'h65, 8'h00, 8'hFF);
		wr(8'h65, 8'hFF);
		rdchk(8'h65, 8'h00, 8'hFF);
		results();
	end
endmodule
